// ==== spmio_top.sv ====
// pin-mode i/o logic of a serial servo controller: pwm, bridges, limits, chain
`timescale 1ns/1ps
`default_nettype none
module spmio_top
    import spmio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic rev_limit_or_step_in,
    input wire logic fwd_limit_or_dir_in,
    input wire logic encoder_index_in,
    input wire logic encoder_chan_a,
    input wire logic encoder_chan_b,
    input wire logic hall_sense_zero,
    input wire logic hall_sense_one,
    input wire logic hall_sense_two,
    input wire logic chain_in,
    input wire logic [1:0] output_mode,
    input wire logic step_dir_mode,
    input wire logic address_set,
    input wire logic servo_fault,
    input wire logic tx_busy,
    input wire logic amp_enable,
    input wire logic [PWM_BITS-1:0] motor_duty,
    input wire logic motor_reverse,
    input wire logic [BAUD_W-1:0] baud_divisor,
    output logic pwm_out_zero,
    output logic pwm_out_one,
    output logic pwm_out_two_or_direction,
    output logic bridge_enable_zero,
    output logic bridge_enable_one,
    output logic bridge_enable_two,
    output logic chain_out,
    output logic comm_enable,
    output logic tx_enable,
    output logic step_pulse,
    output logic step_direction,
    output logic fwd_limit,
    output logic rev_limit,
    output logic index_level,
    output logic [2:0] hall_state,
    output logic servo_tick,
    output logic baud_tick,
    output logic [ENC_W-1:0] enc_count
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_s;
    logic rev_s, fwd_s, idx_s, encoder_chan_a_s, encoder_chan_b_s, chain_in_s;
    logic [2:0] hall_s;

    spmio_sync2 #(.WIDTH(SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .async_in({chain_in, hall_sense_two, hall_sense_one, hall_sense_zero, encoder_chan_b,
                   encoder_chan_a, encoder_index_in, fwd_limit_or_dir_in, rev_limit_or_step_in, 1'b0}),
        .sync_out(pins_s)
    );

    // unpack synced bits; bit 0 is a spare tied low
    assign rev_s = pins_s[1];
    assign fwd_s = pins_s[2];
    assign idx_s = pins_s[3];
    assign encoder_chan_a_s = pins_s[4];
    assign encoder_chan_b_s = pins_s[5];
    assign hall_s = pins_s[8:6];
    assign chain_in_s = pins_s[9];

    // ------------------------------------------------------------
    // pwm timebase and servo tick
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_cnt, next_presc_cnt;
    logic [PWM_BITS-1:0] pwm_cnt, next_pwm_cnt;
    logic [3:0] period_cnt, next_period_cnt;
    logic pwm_level, next_pwm_level;
    logic next_servo_tick;

    // prescale is integer, so at 50 MHz it truncates to 2 and the pwm runs about a quarter above the nominal rate
    always_comb begin
        next_presc_cnt = presc_cnt;
        next_pwm_cnt = pwm_cnt;
        next_period_cnt = period_cnt;
        next_servo_tick = 1'b0;
        if (presc_cnt == PRESC_LAST) begin
            next_presc_cnt = '0;
            next_pwm_cnt = pwm_cnt + 1'b1;
            if (pwm_cnt == PWM_LAST) begin
                if (period_cnt == SERVO_LAST) begin
                    next_period_cnt = '0;
                    next_servo_tick = 1'b1;
                end else begin
                    next_period_cnt = period_cnt + 1'b1;
                end
            end
        end else begin
            next_presc_cnt = presc_cnt + 1'b1;
        end
        next_pwm_level = (pwm_cnt < motor_duty);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            presc_cnt <= '0;
            pwm_cnt <= '0;
            period_cnt <= '0;
            pwm_level <= 1'b0;
            servo_tick <= 1'b0;
        end else begin
            presc_cnt <= next_presc_cnt;
            pwm_cnt <= next_pwm_cnt;
            period_cnt <= next_period_cnt;
            pwm_level <= next_pwm_level;
            servo_tick <= next_servo_tick;
        end
    end

    // ------------------------------------------------------------
    // limit / step / direction / hall pin decode
    // ------------------------------------------------------------
    logic step_prev, next_step_prev;
    logic next_step_pulse, next_step_direction, next_fwd_limit, next_rev_limit, next_index_level;
    logic [2:0] next_hall_state;

    // one pulse per rising edge; 50 MHz sampling easily covers 100 kHz stepping
    always_comb begin
        next_step_prev = rev_s;
        next_step_pulse = step_dir_mode && rev_s && !step_prev;
        next_step_direction = step_dir_mode ? fwd_s : step_direction;
        next_rev_limit = !step_dir_mode && rev_s;
        next_fwd_limit = !step_dir_mode && fwd_s;
        next_index_level = idx_s;
        next_hall_state = hall_s;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            step_prev <= 1'b0;
            step_pulse <= 1'b0;
            step_direction <= FORWARD_DIR;
            rev_limit <= 1'b0;
            fwd_limit <= 1'b0;
            index_level <= 1'b0;
            hall_state <= '0;
        end else begin
            step_prev <= next_step_prev;
            step_pulse <= next_step_pulse;
            step_direction <= next_step_direction;
            rev_limit <= next_rev_limit;
            fwd_limit <= next_fwd_limit;
            index_level <= next_index_level;
            hall_state <= next_hall_state;
        end
    end

    // ------------------------------------------------------------
    // quadrature encoder counter (x4)
    // ------------------------------------------------------------
    logic encoder_chan_a_prev, encoder_chan_b_prev, next_encoder_chan_a_prev, next_encoder_chan_b_prev;
    logic [ENC_W-1:0] next_enc_count;

    // a double transition is a missed edge and is dropped rather than guessed
    always_comb begin
        next_encoder_chan_a_prev = encoder_chan_a_s;
        next_encoder_chan_b_prev = encoder_chan_b_s;
        next_enc_count = enc_count;
        if ((encoder_chan_a_s ^ encoder_chan_a_prev) != (encoder_chan_b_s ^ encoder_chan_b_prev)) begin
            if (encoder_chan_a_prev ^ encoder_chan_b_s) begin
                next_enc_count = enc_count + 1'b1;
            end else begin
                next_enc_count = enc_count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            encoder_chan_a_prev <= 1'b0;
            encoder_chan_b_prev <= 1'b0;
            enc_count <= '0;
        end else begin
            encoder_chan_a_prev <= next_encoder_chan_a_prev;
            encoder_chan_b_prev <= next_encoder_chan_b_prev;
            enc_count <= next_enc_count;
        end
    end

    // ------------------------------------------------------------
    // bridge drive per output mode
    // ------------------------------------------------------------
    logic [2:0] hi_side, lo_side;
    logic next_pwm_out_zero, next_pwm_out_one, next_pwm2, next_en0, next_en1, next_en2;

    // 120-degree table; an illegal hall code floats every bridge
    always_comb begin
        hi_side = 3'h0;
        lo_side = 3'h0;
        unique case (hall_state)
            3'h5: begin hi_side = 3'h1; lo_side = 3'h2; end
            3'h4: begin hi_side = 3'h1; lo_side = 3'h4; end
            3'h6: begin hi_side = 3'h2; lo_side = 3'h4; end
            3'h2: begin hi_side = 3'h2; lo_side = 3'h1; end
            3'h3: begin hi_side = 3'h4; lo_side = 3'h1; end
            3'h1: begin hi_side = 3'h4; lo_side = 3'h2; end
            default: begin hi_side = 3'h0; lo_side = 3'h0; end
        endcase
        if (motor_reverse == REVERSE_DIR) begin
            {hi_side, lo_side} = {lo_side, hi_side};
        end
        next_pwm_out_zero = 1'b0;
        next_pwm_out_one = 1'b0;
        next_pwm2 = 1'b0;
        next_en0 = 1'b0;
        next_en1 = 1'b0;
        next_en2 = 1'b0;
        if (output_mode == MODE_PWM_DIR) begin
            next_pwm_out_zero = pwm_level;
            next_pwm2 = motor_reverse;
            next_en0 = amp_enable;
        end else if (output_mode == MODE_ANTIPHASE) begin
            next_pwm_out_zero = pwm_level;
            next_en0 = amp_enable;
        end else if (output_mode == MODE_THREE_PHASE) begin
            next_pwm_out_zero = pwm_level && hi_side[0];
            next_pwm_out_one = pwm_level && hi_side[1];
            next_pwm2 = pwm_level && hi_side[2];
            next_en0 = amp_enable && (hi_side[0] || lo_side[0]);
            next_en1 = amp_enable && (hi_side[1] || lo_side[1]);
            next_en2 = amp_enable && (hi_side[2] || lo_side[2]);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwm_out_zero <= 1'b0;
            pwm_out_one <= 1'b0;
            pwm_out_two_or_direction <= 1'b0;
            bridge_enable_zero <= 1'b0;
            bridge_enable_one <= 1'b0;
            bridge_enable_two <= 1'b0;
        end else begin
            pwm_out_zero <= next_pwm_out_zero;
            pwm_out_one <= next_pwm_out_one;
            pwm_out_two_or_direction <= next_pwm2;
            bridge_enable_zero <= next_en0;
            bridge_enable_one <= next_en1;
            bridge_enable_two <= next_en2;
        end
    end

    // ------------------------------------------------------------
    // address chain, serial enable, baud tick
    // ------------------------------------------------------------
    logic addressed, next_addressed, next_chain_out, next_comm_enable, next_tx_enable, next_baud_tick;
    logic [1:0] sync_fill, next_sync_fill;
    logic [BAUD_W-1:0] baud_cnt, next_baud_cnt, baud_lim;

    // divisor is clamped so an out-of-range request still lands on a tested rate
    always_comb begin
        next_addressed = addressed || address_set;
        next_chain_out = !next_addressed || (step_dir_mode && servo_fault);
        next_sync_fill = {sync_fill[0], 1'b1}; // sync output reads low until two edges after reset
        next_comm_enable = !chain_in_s && sync_fill[1];
        next_tx_enable = next_comm_enable && tx_busy;
        if (baud_divisor < BAUD_DIV_MIN) begin
            baud_lim = BAUD_DIV_MIN;
        end else if (baud_divisor > BAUD_DIV_MAX) begin
            baud_lim = BAUD_DIV_MAX;
        end else begin
            baud_lim = baud_divisor;
        end
        next_baud_tick = 1'b0;
        next_baud_cnt = baud_cnt + 1'b1;
        if (baud_cnt >= baud_lim - 1'b1) begin
            next_baud_cnt = '0;
            next_baud_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addressed <= 1'b0;
            sync_fill <= '0;
            chain_out <= 1'b1;
            comm_enable <= 1'b0;
            tx_enable <= 1'b0;
            baud_cnt <= '0;
            baud_tick <= 1'b0;
        end else begin
            addressed <= next_addressed;
            sync_fill <= next_sync_fill;
            chain_out <= next_chain_out;
            comm_enable <= next_comm_enable;
            tx_enable <= next_tx_enable;
            baud_cnt <= next_baud_cnt;
            baud_tick <= next_baud_tick;
        end
    end

    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    property p_chain_low_addr;
        @(posedge clk_sys) disable iff (!arst_n) (address_set && !step_dir_mode) |=> !chain_out;
    endproperty
    a_chain_low_addr: assert property (p_chain_low_addr) else $error("chain output not low after addressing");

    property p_chain_high_unaddr;
        @(posedge clk_sys) disable iff (!arst_n) !addressed |-> chain_out;
    endproperty
    a_chain_high_unaddr: assert property (p_chain_high_unaddr) else $error("chain output low before addressing");

    property p_fault_chain;
        @(posedge clk_sys) disable iff (!arst_n) (step_dir_mode && servo_fault) |=> chain_out;
    endproperty
    a_fault_chain: assert property (p_fault_chain) else $error("fault did not raise chain output");

    property p_step_single;
        @(posedge clk_sys) disable iff (!arst_n) step_pulse |-> $past(step_dir_mode) ##1 !step_pulse;
    endproperty
    a_step_single: assert property (p_step_single) else $error("step pulse wrong length or mode");

    property p_limits_gated;
        @(posedge clk_sys) disable iff (!arst_n) step_dir_mode |=> (!fwd_limit && !rev_limit);
    endproperty
    a_limits_gated: assert property (p_limits_gated) else $error("limit reported in step mode");

    property p_pwm_out_one_idle;
        @(posedge clk_sys) disable iff (!arst_n)
            (output_mode != MODE_THREE_PHASE) |=> (!pwm_out_one && !bridge_enable_one && !bridge_enable_two);
    endproperty
    a_pwm_out_one_idle: assert property (p_pwm_out_one_idle) else $error("bridge one or two active outside three-phase");

    property p_dir_bit;
        @(posedge clk_sys) disable iff (!arst_n)
            (output_mode == MODE_PWM_DIR) |=> (pwm_out_two_or_direction == $past(motor_reverse));
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("direction pin mismatch");

    property p_amp_enable;
        @(posedge clk_sys) disable iff (!arst_n)
            (output_mode == MODE_PWM_DIR || output_mode == MODE_ANTIPHASE) |=> (bridge_enable_zero == $past(amp_enable));
    endproperty
    a_amp_enable: assert property (p_amp_enable) else $error("amplifier enable mismatch");

    property p_hall_illegal;
        @(posedge clk_sys) disable iff (!arst_n)
            (output_mode == MODE_THREE_PHASE && (hall_state == 3'h0 || hall_state == 3'h7))
            |=> !(bridge_enable_zero || bridge_enable_one || bridge_enable_two);
    endproperty
    a_hall_illegal: assert property (p_hall_illegal) else $error("bridge enabled on illegal hall code");

    property p_comm_off;
        @(posedge clk_sys) disable iff (!arst_n) chain_in_s |=> (!comm_enable && !tx_enable);
    endproperty
    a_comm_off: assert property (p_comm_off) else $error("serial enabled while chain input high");

    property p_baud_spacing;
        @(posedge clk_sys) disable iff (!arst_n) baud_tick |=> !baud_tick [*8];
    endproperty
    a_baud_spacing: assert property (p_baud_spacing) else $error("baud tick faster than allowed");

    property p_servo_wrap;
        @(posedge clk_sys) disable iff (!arst_n) servo_tick |-> (period_cnt == '0 && pwm_cnt == '0);
    endproperty
    a_servo_wrap: assert property (p_servo_wrap) else $error("servo tick off period boundary");

    c_step: cover property (@(posedge clk_sys) disable iff (!arst_n) step_pulse);
    c_servo: cover property (@(posedge clk_sys) disable iff (!arst_n) servo_tick);
    c_chain_fall: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(chain_out));
    c_three_phase: cover property (@(posedge clk_sys) disable iff (!arst_n) bridge_enable_one && pwm_out_one);

endmodule
`default_nettype wire

// ==== spmio_pkg.sv ====
// constants shared by the servo pin-mode i/o block
package spmio_pkg;

    // ------------------------------------------------------------
    // clocking and derived rates
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int REF_PLL_MULT = 4;
    localparam int REF_CORE_HZ = REF_CLK_HZ * REF_PLL_MULT;
    localparam int PWM_FREQ_HZ = 19_531;
    localparam int PWM_BITS = 10;
    localparam int PWM_STEPS = 1024;
    localparam int PWM_PRESCALE_RAW = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
    localparam int PWM_PRESCALE = (PWM_PRESCALE_RAW < 1) ? 1 : PWM_PRESCALE_RAW;
    localparam int PRESC_W = 4;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PWM_PRESCALE - 1);
    localparam logic [PWM_BITS-1:0] PWM_LAST = 10'h3ff;
    localparam int SERVO_PWM_PERIODS = 10;
    localparam logic [3:0] SERVO_LAST = 4'(SERVO_PWM_PERIODS - 1);

    // ------------------------------------------------------------
    // serial and step limits
    // ------------------------------------------------------------
    localparam int BAUD_MIN = 9_600;
    localparam int BAUD_MAX = 230_400;
    localparam int BAUD_W = 13;
    localparam logic [BAUD_W-1:0] BAUD_DIV_MAX = BAUD_W'(CLK_HZ / BAUD_MIN);
    localparam logic [BAUD_W-1:0] BAUD_DIV_MIN = BAUD_W'(CLK_HZ / BAUD_MAX);
    localparam int STEP_MAX_HZ = 100_000;
    localparam int STEP_MIN_CYC = CLK_HZ / STEP_MAX_HZ;
    localparam int ENC_W = 16;

    // ------------------------------------------------------------
    // output modes and direction codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_PWM_DIR = 2'h0;
    localparam logic [1:0] MODE_ANTIPHASE = 2'h1;
    localparam logic [1:0] MODE_THREE_PHASE = 2'h2;
    localparam logic FORWARD_DIR = 1'b0;
    localparam logic REVERSE_DIR = 1'b1;
    localparam int SYNC_W = 10;

endpackage

// ==== spmio_sync2.sv ====
// two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
`default_nettype none
module spmio_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // ------------------------------------------------------------
    // per-bit flop pair; first stage feeds only the second
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    stage_one[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage_one[i] <= async_in[i];
                    sync_out[i] <= stage_one[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ==== spmio_plant.sv ====
// behavioural motor side: quadrature encoder, index and hall sensors
`timescale 1ns/1ps
`default_nettype none
module spmio_plant (
    input wire logic clk_sys,
    input wire logic enc_run,
    input wire logic [2:0] hall_code,
    output logic encoder_chan_a,
    output logic encoder_chan_b,
    output logic encoder_index_in,
    output logic hall_sense_zero,
    output logic hall_sense_one,
    output logic hall_sense_two
);
    logic [4:0] div = 5'h00;
    logic [1:0] phase = 2'h0;
    // ------------------------------------------------------------
    // encoder: one step per 20 clocks keeps edges at 2.5 MHz
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        div <= (!enc_run || div == 5'h13) ? 5'h00 : div + 5'h01;
        if (enc_run && div == 5'h13) begin
            phase <= phase + 2'h1;
        end
    end
    // gray order 00,01,11,10 counts up in the block's sense
    assign encoder_chan_a = phase[1];
    assign encoder_chan_b = phase[1] ^ phase[0];
    assign encoder_index_in = (phase == 2'h0) & enc_run;
    // halls follow the commanded sector, no filtering
    assign {hall_sense_two, hall_sense_one, hall_sense_zero} = hall_code;
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the servo pin-mode i/o block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spmio_pkg::*;
    localparam logic [31:0] HALL_MAP = 32'h0612_8490;
    logic clk_sys = 1'b0, arst_n = 1'b0, rev_limit_or_step_in = 1'b0, fwd_limit_or_dir_in = 1'b0;
    logic chain_in = 1'b1, step_dir_mode = 1'b0, address_set = 1'b0, servo_fault = 1'b0;
    logic tx_busy = 1'b0, amp_enable = 1'b0, motor_reverse = 1'b0, enc_run = 1'b0, pwm_prev = 1'b0;
    logic [1:0] output_mode = 2'h0;
    logic [2:0] hall_code = 3'h0, seen;
    logic [PWM_BITS-1:0] motor_duty = 10'h000;
    logic [BAUD_W-1:0] baud_divisor = 13'h0064;
    logic encoder_index_in, encoder_chan_a, encoder_chan_b, hall_sense_zero, hall_sense_one, hall_sense_two;
    logic pwm_out_zero, pwm_out_one, pwm_out_two_or_direction, bridge_enable_zero, bridge_enable_one;
    logic bridge_enable_two, chain_out, comm_enable, tx_enable, step_pulse, step_direction;
    logic fwd_limit, rev_limit, index_level, servo_tick, baud_tick;
    logic [2:0] hall_state;
    logic [ENC_W-1:0] enc_count;
    int bad_count = 0, n_compared = 0, n_steps = 0, g, n_high;
    int seed = 32'h85cd;

    always #10 clk_sys = ~clk_sys;
    // step pulses and pwm history kept for later comparison
    always @(posedge clk_sys) begin
        pwm_prev <= pwm_out_zero;
        if (step_pulse === 1'b1) n_steps <= n_steps + 1;
    end

    spmio_plant plant (.clk_sys, .enc_run, .hall_code, .encoder_chan_a, .encoder_chan_b, .encoder_index_in,
        .hall_sense_zero, .hall_sense_one, .hall_sense_two);
    spmio_top dut (.clk_sys, .arst_n, .rev_limit_or_step_in, .fwd_limit_or_dir_in, .encoder_index_in,
        .encoder_chan_a, .encoder_chan_b, .hall_sense_zero, .hall_sense_one, .hall_sense_two, .chain_in,
        .output_mode, .step_dir_mode, .address_set, .servo_fault, .tx_busy, .amp_enable, .motor_duty,
        .motor_reverse, .baud_divisor, .pwm_out_zero, .pwm_out_one, .pwm_out_two_or_direction,
        .bridge_enable_zero, .bridge_enable_one, .bridge_enable_two, .chain_out, .comm_enable, .tx_enable,
        .step_pulse, .step_direction, .fwd_limit, .rev_limit, .index_level, .hall_state, .servo_tick,
        .baud_tick, .enc_count);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report;
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // settle to the falling edge so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    function automatic logic hit(input int w);
        if (w == 0) return baud_tick === 1'b1;
        if (w == 1) return servo_tick === 1'b1;
        return pwm_out_zero === 1'b1 && pwm_prev === 1'b0;
    endfunction
    // cycles between two events; bounded so a dead counter cannot hang
    task automatic gap(input int w, output int n);
        int i;
        i = 0;
        @(negedge clk_sys);
        while (!hit(w) && i < 30000) begin
            @(negedge clk_sys);
            i++;
        end
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (!hit(w) && n < 30000);
    endtask
    // {en2,en1,en0,pwm2,pwm_out_one,pwm_out_zero} with duty at full scale
    function automatic logic [5:0] exp_out(input logic [1:0] m, input logic en, input logic rv,
        input logic [2:0] h);
        logic [5:0] r;
        logic [1:0] hi, lo, t;
        r = 6'h00;
        hi = 2'(HALL_MAP >> (4 * h + 2));
        lo = 2'(HALL_MAP >> (4 * h));
        if (rv) begin
            t = hi;
            hi = lo;
            lo = t;
        end
        if (m == 2'h0) r = {2'b00, en, rv, 2'b01};
        if (m == 2'h1) r = {2'b00, en, 3'b001};
        if (m == 2'h2 && h != 3'h0 && h != 3'h7) begin
            r[hi] = 1'b1;
            r[3 + hi] = en;
            r[3 + lo] = en;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        enc_run <= 1'b1;
        cyc(4);
        chk("chain_out", 1, chain_out);
        chk("index_level", 1, index_level);
        repeat (116) @(posedge clk_sys);
        enc_run <= 1'b0;
        cyc(6);
        chk("enc_count", 6, enc_count);
        @(posedge clk_sys);
        address_set <= 1'b1;
        @(posedge clk_sys);
        address_set <= 1'b0;
        cyc(0);
        chk("chain_out", 0, chain_out);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            step_dir_mode <= i[1];
            servo_fault <= i[0];
            cyc(2);
            chk("chain_out", i[1] & i[0], chain_out);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            step_dir_mode <= m[0];
            cyc(4);
            n_steps = 0;
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_sys);
                {fwd_limit_or_dir_in, rev_limit_or_step_in} <= 2'(i);
                cyc(m ? 500 : 4);
                chk("limits", m ? 0 : i, {fwd_limit, rev_limit});
                if (m) chk("step_direction", i / 2, step_direction);
            end
            chk("step count", 2 * m, n_steps);
        end
        @(posedge clk_sys);
        step_dir_mode <= 1'b0;
        motor_duty <= 10'h3ff;
        for (int k = 0; k < 48; k++) begin
            @(posedge clk_sys);
            output_mode <= (k < 4) ? 2'(k) : 2'($random(seed));
            amp_enable <= (k < 4) ? 1'b1 : 1'($random(seed));
            motor_reverse <= 1'($random(seed));
            hall_code <= 3'($random(seed));
            cyc(6);
            seen = 3'h0;
            for (int j = 0; j < 16; j++) begin
                seen |= {pwm_out_two_or_direction, pwm_out_one, pwm_out_zero};
                @(negedge clk_sys);
            end
            chk("bridges", exp_out(output_mode, amp_enable, motor_reverse, hall_code),
                {bridge_enable_two, bridge_enable_one, bridge_enable_zero, seen});
            chk("hall_state", hall_code, hall_state);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            chain_in <= i[1];
            tx_busy <= i[0];
            cyc(4);
            chk("comm", {~i[1], ~i[1] & i[0]}, {comm_enable, tx_enable});
        end
        @(posedge clk_sys);
        chain_in <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            g = (i == 0) ? 100 : (i == 1) ? 300 : 8000;
            baud_divisor <= 13'(g);
            g = (g < int'(BAUD_DIV_MIN)) ? int'(BAUD_DIV_MIN) : (g > int'(BAUD_DIV_MAX)) ? int'(BAUD_DIV_MAX) : g;
            cyc(1);
            gap(0, n_steps);
            chk("baud gap", g, n_steps);
        end
        @(posedge clk_sys);
        output_mode <= MODE_PWM_DIR;
        motor_duty <= 10'h200;
        // a mode switch can raise the pin mid-period; let it pass before timing edges
        cyc(4);
        gap(2, g);
        chk("pwm period", PWM_PRESCALE * PWM_STEPS, g);
        n_high = 0;
        repeat (PWM_PRESCALE * PWM_STEPS) begin
            n_high += (pwm_out_zero === 1'b1);
            @(negedge clk_sys);
        end
        chk("pwm high time", PWM_PRESCALE * int'(motor_duty), n_high);
        gap(1, g);
        chk("servo period", PWM_PRESCALE * PWM_STEPS * SERVO_PWM_PERIODS, g);
        final_report();
    end
    // hang guard: about 95k cycles, well past the ~61k a clean run needs
    initial begin
        #1_900_000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
